// file: lld_core.sv
// Command decode, read sequencing, termination and write commit of the DRAM core.
// Assumes command pins are synchronous to I_CLK; I_CLK_BAD is asynchronous.
//
// Behaviour
// - Terminate data and mask lines only
// - Data termination off while driving reads
// - Mask input always terminated when enabled
// - Idle starts nothing, cancels nothing
// - Read: select low, write and refresh high
// - Write: select and write low, refresh high
// - Deselect, mode set, refresh decode; no strobe combination is illegal
// - Split mode: second part next edge
// - Valid flag leads data by half cycle
// - Output strobe toggles continuously
// - Float data, drop flag on last item
// - Bad clock holds flag until read
// - Back-to-back reads stream without gaps
// - Write latency is read latency plus one
// - Masked write items are not stored
// - Refresh needs bank only, back-to-back allowed
// - Mode set takes address bits 0 to 17
// - Command, address and bank sampled on rising main clock
// - Split mode adds one latency cycle
// - Burst length two, four or eight
// - Configuration code sets the latencies
`timescale 1ns/1ns
`default_nettype none
module lld_core
    import lld_pkg::*;
#(
    parameter int DW = 9,   // Bits per data item
    parameter int AW = 22   // Address pins
)(
    input wire logic I_CLK,                         // Main clock
    input wire logic I_RST_N,                       // Async reset, active low
    input wire logic I_INPUT_DATA_STROBE,           // Write strobe clock
    input wire logic I_CS_N,                        // Chip select, active low
    input wire logic I_WE_N,                        // Write enable, active low
    input wire logic I_REF_N,                       // Refresh strobe, active low
    input wire logic [AW-1:0] I_ADDR,               // Address or address part
    input wire logic [2:0] I_BA,                    // Bank address
    input wire logic [2*DW-1:0] I_DQ,               // Write items {fall, rise}
    input wire logic [1:0] I_WRITE_MASK,            // Mask {fall, rise}
    input wire logic I_CLK_BAD,                     // Main clock out of range
    output logic [2*DW-1:0] O_DQ,                   // Read items {fall, rise}
    output logic O_DQ_OE,                           // Data pins driven
    output logic [1:0] O_READ_VALID_FLAG,           // Flag {fall, rise half}
    output logic O_OUTPUT_DATA_STROBE,              // Free-running strobe
    output logic O_TERM_DQ,                         // Data line termination on
    output logic O_TERM_MASK,                       // Mask line termination on
    output logic O_REF_DONE,                        // Refresh accepted pulse
    output logic [OP_W-1:0] O_MODE                  // Mode register
);
    typedef enum {AS_IDLE, AS_SECOND} lld_as_t;

    lld_ctl_t ctl;
    logic [AW-1:0] addr;
    logic [2:0] bank;
    lld_cmd_t cmd;
    lld_as_t ast;
    lld_as_t next_ast;
    logic [2:0] pend_bank;
    logic [2:0] next_bank;
    logic pend_wr;
    logic next_wr;
    logic next_ref;
    logic [OP_W-1:0] next_mode;
    logic go_rd;
    logic go_wr;
    logic [IDX_W-1:0] go_base;
    logic split;
    logic [3:0] read_lat;
    logic [3:0] write_lat;
    logic [2:0] burst_beats;
    logic [2:0] rd_slot;
    logic [2:0] wr_slot;
    lld_ent_t [MAX_LAT-1:0] rd_pipe;
    lld_ent_t [MAX_LAT-1:0] wr_pipe;
    lld_ent_t [MAX_LAT-1:0] next_rd_pipe;
    lld_ent_t [MAX_LAT-1:0] next_wr_pipe;
    logic [1:0] sync_q;
    logic clk_bad;
    logic done_sync;
    logic done_seen;
    logic start_tgl;
    logic next_start;
    logic [IDX_W-1:0] wbase;
    logic [IDX_W-1:0] next_wbase;
    logic [MAX_ITEMS*DW-1:0] stage_data;
    logic [MAX_ITEMS-1:0] stage_keep;
    logic done_tgl;
    logic [DW-1:0] mem [2**IDX_W];
    logic [DW-1:0] next_mem [2**IDX_W];
    logic start;
    logic drive;
    logic [IDX_W-1:0] cur_ptr;
    logic [2:0] cnt;
    logic [IDX_W-1:0] ptr;
    logic [IDX_W-1:0] next_ptr;
    logic [2:0] beats_left;
    logic [2:0] next_beats;
    logic stick;
    logic next_stick;
    logic [2*DW-1:0] next_dq;
    logic [1:0] next_flag;

    // Storage index from bank and low address bits
    function automatic logic [IDX_W-1:0] item_index(input logic [2:0] b,
                                                    input logic [IDX_W-4:0] a);
        return {b, a};
    endfunction

    lld_sync #(.W(2)) u_sync (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_d({I_CLK_BAD, done_tgl}),
        .o_q(sync_q)
    );
    assign clk_bad = sync_q[1];
    assign done_sync = sync_q[0];

    lld_strobe_cap #(.DW(DW)) u_cap (
        .i_strobe_clk(I_INPUT_DATA_STROBE),
        .i_rst_n(I_RST_N),
        .i_start_tgl(start_tgl),
        .i_beats(burst_beats),
        .i_data(I_DQ),
        .i_mask(I_WRITE_MASK),
        .o_data(stage_data),
        .o_keep(stage_keep),
        .o_done_tgl(done_tgl)
    );

    // Command, address and bank sampled on the rising main clock edge
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ctl <= 3'h7;
            addr <= '0;
            bank <= 3'h0;
        end
        else
        begin
            ctl <= {I_CS_N, I_WE_N, I_REF_N};
            addr <= I_ADDR;
            bank <= I_BA;
        end
    end

    // Decode and latency derivation from the mode register
    assign cmd = lld_decode(ctl);
    assign split = O_MODE[AM_BIT];
    assign read_lat = lld_lat(O_MODE[CFG_LSB+2:CFG_LSB], split);
    assign write_lat = read_lat + 4'h1;
    assign burst_beats = lld_beats(O_MODE[BL_LSB+1:BL_LSB]);
    assign rd_slot = 3'(read_lat - SLOT_OFS - {3'h0, split});
    assign wr_slot = 3'(write_lat - SLOT_OFS - {3'h0, split});

    // Command acceptance, split-address assembly and mode set
    always_comb
    begin
        next_ast = ast;
        next_bank = pend_bank;
        next_wr = pend_wr;
        next_ref = 1'b0;
        next_mode = O_MODE;
        go_rd = 1'b0;
        go_wr = 1'b0;
        go_base = '0;
        case (ast)
            AS_SECOND:
            begin
                go_rd = !pend_wr;
                go_wr = pend_wr;
                go_base = item_index(pend_bank, {addr[IDX_W-SPLIT_W-4+SPLIT_W:0]});
                next_ast = AS_IDLE;
            end
            default:
            begin
                case (cmd)
                    CMD_READ, CMD_WRITE:
                    begin
                        if (split)
                        begin
                            next_ast = AS_SECOND;
                            next_bank = bank;
                            next_wr = (cmd == CMD_WRITE);
                        end
                        else
                        begin
                            go_rd = (cmd == CMD_READ);
                            go_wr = (cmd == CMD_WRITE);
                            go_base = item_index(bank, addr[IDX_W-4:0]);
                        end
                    end
                    CMD_REF: next_ref = 1'b1;
                    CMD_MODE:
                    begin
                        next_mode = addr[OP_W-1:0];
                        if (addr[CFG_LSB+2:CFG_LSB+1] == CFG_RSVD)
                            next_mode[CFG_LSB+2:CFG_LSB] = O_MODE[CFG_LSB+2:CFG_LSB];
                        if (addr[BL_LSB+1:BL_LSB] == BL_RSVD)
                            next_mode[BL_LSB+1:BL_LSB] = O_MODE[BL_LSB+1:BL_LSB];
                    end
                    default: next_ref = 1'b0;
                endcase
            end
        endcase
    end

    // Command state registers
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ast <= AS_IDLE;
            pend_bank <= 3'h0;
            pend_wr <= 1'b0;
            O_REF_DONE <= 1'b0;
            O_MODE <= MODE_RST;
        end
        else
        begin
            ast <= next_ast;
            pend_bank <= next_bank;
            pend_wr <= next_wr;
            O_REF_DONE <= next_ref;
            O_MODE <= next_mode;
        end
    end

    // Latency pipes; accepted accesses always run out, whatever follows
    always_comb
    begin
        next_rd_pipe = {lld_ent_t'('0), rd_pipe[MAX_LAT-1:1]};
        next_wr_pipe = {lld_ent_t'('0), wr_pipe[MAX_LAT-1:1]};
        if (go_rd)
            next_rd_pipe[rd_slot] = '{v: 1'b1, base: go_base};
        if (go_wr)
            next_wr_pipe[wr_slot] = '{v: 1'b1, base: go_base};
    end

    // Write window launch and commit of captured items
    always_comb
    begin
        next_start = start_tgl;
        next_wbase = wbase;
        next_mem = mem;
        if (wr_pipe[0].v)
        begin
            next_start = ~start_tgl;
            next_wbase = wr_pipe[0].base;
        end
        if (done_sync != done_seen)
        begin
            for (int k = 0; k < MAX_ITEMS; k++)
            begin
                if (stage_keep[k])
                    next_mem[IDX_W'(wbase + k)] = stage_data[k*DW +: DW];
            end
        end
    end

    // Pipe and write control registers
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rd_pipe <= '0;
            wr_pipe <= '0;
            start_tgl <= 1'b0;
            wbase <= '0;
            done_seen <= 1'b0;
        end
        else
        begin
            rd_pipe <= next_rd_pipe;
            wr_pipe <= next_wr_pipe;
            start_tgl <= next_start;
            wbase <= next_wbase;
            done_seen <= done_sync;
        end
    end

    // Item storage, no reset
    always_ff @(posedge I_CLK)
    begin
        mem <= next_mem;
    end

    // Read burst engine: two items per cycle, flag in half-cycle phases
    always_comb
    begin
        start = rd_pipe[0].v;
        cur_ptr = start ? rd_pipe[0].base : ptr;
        cnt = start ? burst_beats : beats_left;
        drive = start || (beats_left != 3'h0);
        next_ptr = IDX_W'(cur_ptr + 2);
        next_beats = drive ? cnt - 3'h1 : 3'h0;
        next_dq = drive ? {mem[IDX_W'(cur_ptr + 1)], mem[cur_ptr]} : '0;
        next_stick = stick;
        if (clk_bad && (drive || O_DQ_OE))
            next_stick = 1'b1;
        else if (go_rd)
            next_stick = 1'b0;
        next_flag[0] = drive || stick;
        next_flag[1] = (drive && cnt != 3'h1) || rd_pipe[1].v || stick;
    end

    // Read output registers; strobe and termination
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ptr <= '0;
            beats_left <= 3'h0;
            stick <= 1'b0;
            O_DQ <= '0;
            O_DQ_OE <= 1'b0;
            O_READ_VALID_FLAG <= 2'h0;
            O_OUTPUT_DATA_STROBE <= 1'b0;
            O_TERM_DQ <= 1'b0;
            O_TERM_MASK <= 1'b0;
        end
        else
        begin
            ptr <= next_ptr;
            beats_left <= next_beats;
            stick <= next_stick;
            O_DQ <= next_dq;
            O_DQ_OE <= drive;
            O_READ_VALID_FLAG <= next_flag;
            O_OUTPUT_DATA_STROBE <= ~O_OUTPUT_DATA_STROBE;
            O_TERM_DQ <= O_MODE[TERM_BIT] && !drive;
            O_TERM_MASK <= O_MODE[TERM_BIT];
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence lead_s;
        O_READ_VALID_FLAG[1] ##1 (O_DQ_OE && O_READ_VALID_FLAG[0]);
    endsequence

    sequence split_s;
        (ast == AS_SECOND) ##1 (ast == AS_IDLE);
    endsequence

    term_mask_a: assert property (1'b1 |=> O_TERM_MASK == $past(O_MODE[TERM_BIT]))
        else $error("mask termination does not follow enable");
    term_read_a: assert property (O_DQ_OE |-> !O_TERM_DQ)
        else $error("data termination on while driving");
    term_back_a: assert property (($fell(O_DQ_OE) && $past(O_MODE[TERM_BIT])) |-> O_TERM_DQ)
        else $error("data termination not restored after burst");
    flag_lead_a: assert property (rd_pipe[1].v |=> lead_s)
        else $error("valid flag does not lead read data");
    float_end_a: assert property ((O_DQ_OE && beats_left == 3'h0 && !rd_pipe[0].v && !stick)
        |-> !O_READ_VALID_FLAG[1] ##1 !O_DQ_OE)
        else $error("data not floated or flag held at burst end");
    strobe_run_a: assert property (1'b1 |=> O_OUTPUT_DATA_STROBE != $past(O_OUTPUT_DATA_STROBE))
        else $error("output strobe stopped");
    flag_stick_a: assert property (stick |=> O_READ_VALID_FLAG == 2'h3)
        else $error("valid flag released while clock fault held");
    burst_len_a: assert property ((start && burst_beats == 3'h4) |=> O_DQ_OE [*4])
        else $error("eight-item burst shorter than four cycles");
    split_addr_a: assert property ((ast == AS_IDLE && split && (cmd == CMD_READ
        || cmd == CMD_WRITE)) |=> split_s)
        else $error("second address part not taken on next edge");
    refresh_a: assert property ((ast == AS_IDLE && cmd == CMD_REF) |=> O_REF_DONE && ast == AS_IDLE)
        else $error("refresh not accepted alone");
endmodule
`default_nettype wire

// file: lld_pkg.sv
// Shared constants, types and decode helpers of the low-latency DRAM core.
// Assumes nothing of its surroundings; every design file except the synchroniser imports it.
package lld_pkg;
    localparam int IDX_W = 6;      // Item storage index width
    localparam int OP_W = 18;      // Operation code width of a mode set
    localparam int SPLIT_W = 11;   // Address lines used per part in split mode
    localparam int CFG_LSB = 0;    // Configuration code field
    localparam int BL_LSB = 3;     // Burst length field
    localparam int AM_BIT = 5;     // Split-address mode bit
    localparam int TERM_BIT = 9;   // Termination enable bit
    localparam int MAX_LAT = 8;    // Latency pipe slots
    localparam int MAX_ITEMS = 8;  // Longest burst in items
    localparam logic [OP_W-1:0] MODE_RST = 18'h00000;
    localparam logic [1:0] BL_4 = 2'h1;
    localparam logic [1:0] BL_8 = 2'h2;
    localparam logic [1:0] BL_RSVD = 2'h3;
    localparam logic [1:0] CFG_RSVD = 2'h3;  // Upper two config bits of codes 6 and 7
    localparam logic [3:0] SLOT_OFS = 4'h2;  // Input register plus output register

    typedef enum {CMD_IDLE, CMD_READ, CMD_WRITE, CMD_REF, CMD_MODE} lld_cmd_t;
    typedef struct packed {logic cs_n; logic we_n; logic ref_n;} lld_ctl_t;
    typedef struct packed {logic v; logic [IDX_W-1:0] base;} lld_ent_t;

    // Command decode from the three strobes
    function automatic lld_cmd_t lld_decode(input lld_ctl_t c);
        lld_cmd_t r;
        if (c.cs_n)
            r = CMD_IDLE;
        else if (c.we_n)
            r = c.ref_n ? CMD_READ : CMD_REF;
        else
            r = c.ref_n ? CMD_WRITE : CMD_MODE;
        return r;
    endfunction

    // Read latency in main clock cycles for a configuration code
    function automatic logic [3:0] lld_lat(input logic [2:0] cfg, input logic split);
        logic [3:0] r;
        case (cfg)
            3'h2: r = 4'h6;
            3'h3: r = 4'h8;
            3'h4: r = 4'h3;
            3'h5: r = 4'h5;
            default: r = 4'h4;
        endcase
        return r + {3'h0, split};
    endfunction

    // Main clock cycles per burst, two items per cycle
    function automatic logic [2:0] lld_beats(input logic [1:0] bl);
        logic [2:0] r;
        case (bl)
            BL_4: r = 3'h2;
            BL_8: r = 3'h4;
            default: r = 3'h1;
        endcase
        return r;
    endfunction
endpackage

// file: lld_sync.sv
// Two flip-flop synchroniser for levels and toggles.
// Assumes the input is stable long enough for the destination clock to see it.
`timescale 1ns/1ns
`default_nettype none
module lld_sync #(
    parameter int W = 1  // Bits synchronised
)(
    input wire logic i_clk,          // Destination clock
    input wire logic i_rst_n,        // Async reset, active low
    input wire logic [W-1:0] i_d,    // Foreign-domain input
    output logic [W-1:0] o_q         // Synchronised output
);
    logic [W-1:0] meta;

    // First stage is read only by the second
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta <= '0;
            o_q <= '0;
        end
        else
        begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule
`default_nettype wire

// file: lld_strobe_cap.sv
// Write data capture on the input data strobe clock.
// Assumes the main domain holds i_beats steady while a window is open.
`timescale 1ns/1ns
`default_nettype none
module lld_strobe_cap
    import lld_pkg::*;
#(
    parameter int DW = 9  // Bits per data item
)(
    input wire logic i_strobe_clk,               // Input data strobe clock
    input wire logic i_rst_n,                    // Async reset, active low
    input wire logic i_start_tgl,                // Window open toggle, main domain
    input wire logic [2:0] i_beats,              // Strobe cycles in the burst
    input wire logic [2*DW-1:0] i_data,          // Items {fall, rise}
    input wire logic [1:0] i_mask,               // Write mask {fall, rise}
    output logic [MAX_ITEMS*DW-1:0] o_data,      // Captured burst
    output logic [MAX_ITEMS-1:0] o_keep,         // Items to store
    output logic o_done_tgl                      // Burst complete toggle
);
    logic start_sync;
    logic start_seen;
    logic [2:0] left;
    logic [1:0] slot;
    logic next_seen;
    logic [2:0] next_left;
    logic [1:0] next_slot;
    logic [MAX_ITEMS*DW-1:0] next_data;
    logic [MAX_ITEMS-1:0] next_keep;
    logic next_done;

    lld_sync #(.W(1)) u_start_sync (
        .i_clk(i_strobe_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_start_tgl),
        .o_q(start_sync)
    );

    // Arm on a start toggle, then take two items per strobe cycle
    always_comb
    begin
        next_seen = start_sync;
        next_left = left;
        next_slot = slot;
        next_data = o_data;
        next_keep = o_keep;
        next_done = o_done_tgl;
        if (start_sync != start_seen)
        begin
            next_left = i_beats;
            next_slot = 2'h0;
            next_keep = '0;
        end
        else if (left != 3'h0)
        begin
            next_data[slot*2*DW +: 2*DW] = i_data;
            next_keep[slot*2 +: 2] = ~i_mask;
            next_slot = slot + 2'h1;
            next_left = left - 3'h1;
            if (left == 3'h1)
                next_done = ~o_done_tgl;
        end
    end

    // Capture state registers
    always_ff @(posedge i_strobe_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            start_seen <= 1'b0;
            left <= 3'h0;
            slot <= 2'h0;
            o_data <= '0;
            o_keep <= '0;
            o_done_tgl <= 1'b0;
        end
        else
        begin
            start_seen <= next_seen;
            left <= next_left;
            slot <= next_slot;
            o_data <= next_data;
            o_keep <= next_keep;
            o_done_tgl <= next_done;
        end
    end
endmodule
`default_nettype wire

// file: lld_ctrl_model.sv
// Controller model: commands, address, write items, mask and strobe.
// Assumes task calls begin just after a rising edge of i_clk.
`timescale 1ns/1ns
`default_nettype none
module lld_ctrl_model
    import lld_pkg::*;
(
    input wire logic i_clk,      // Main clock
    output logic o_strb,         // Input data strobe
    output lld_ctl_t o_ctl,      // Command strobes
    output logic [21:0] o_addr,  // Address
    output logic [2:0] o_ba,     // Bank
    output logic [17:0] o_dq,    // Write items
    output logic [1:0] o_wmask   // Write mask
);
    logic run;
    // Strobe runs only around reset and write windows
    initial
    begin
        run = 1'b1;
        o_strb = 1'b0;
        o_ctl = 3'h7;
        o_addr = 22'h0;
        o_ba = 3'h0;
        o_dq = 18'h0;
        o_wmask = 2'h0;
        forever
        begin
            #32 o_strb = run & ~o_strb;
        end
    end
    // One command per edge, held to the sampling edge
    task automatic issue(input lld_cmd_t c, input logic [21:0] a, input logic [2:0] b);
        case (c)
            CMD_READ: o_ctl = 3'h3;
            CMD_WRITE: o_ctl = 3'h1;
            CMD_REF: o_ctl = 3'h2;
            CMD_MODE: o_ctl = 3'h0;
            default: o_ctl = 3'h7;
        endcase
        o_addr = a;
        o_ba = b;
        @(posedge i_clk);
        #1;
    endtask
    // Items and mask held over the strobe window
    task automatic put(input logic [17:0] d, input logic [1:0] m, input logic on);
        o_dq = d;
        o_wmask = m;
        run = on;
    endtask
endmodule
`default_nettype wire

// file: lld_core_tb.sv
// Bench of the DRAM core, driven through the controller model.
// Assumes the core and the controller model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module lld_core_tb
    import lld_pkg::*;
    ;
    logic clk, rst_n, clk_bad, strb, oe, mstrb, tdq, tmask, refd;
    lld_ctl_t ctl;
    logic [21:0] addr;
    logic [2:0] ba;
    logic [17:0] dq, wdq, stored;
    logic [1:0] wm, vf;
    logic [OP_W-1:0] mode;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    lld_ctrl_model i_lld_ctrl_model (.i_clk(clk), .o_strb(strb), .o_ctl(ctl),
        .o_addr(addr), .o_ba(ba), .o_dq(wdq), .o_wmask(wm));
    lld_core i_lld_core (.I_CLK(clk), .I_RST_N(rst_n), .I_INPUT_DATA_STROBE(strb),
        .I_CS_N(ctl.cs_n), .I_WE_N(ctl.we_n), .I_REF_N(ctl.ref_n), .I_ADDR(addr),
        .I_BA(ba), .I_DQ(wdq), .I_WRITE_MASK(wm), .I_CLK_BAD(clk_bad), .O_DQ(dq),
        .O_DQ_OE(oe), .O_READ_VALID_FLAG(vf), .O_OUTPUT_DATA_STROBE(mstrb),
        .O_TERM_DQ(tdq), .O_TERM_MASK(tmask), .O_REF_DONE(refd), .O_MODE(mode));
    // Main clock, 50 ns
    initial
    begin
        clk = 1'b0;
        forever
        begin
            #25 clk = ~clk;
        end
    end
    // Cycle ceiling against hangs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n)
            i_lld_ctrl_model.issue(CMD_IDLE, ~addr, ba);
    endtask
    task automatic ms(input logic [21:0] op, input logic [17:0] e);
        i_lld_ctrl_model.issue(CMD_MODE, op, 3'h0);
        idle(2);
        check("mode", e, mode);
    endtask
    // Read of bank 2 address 5, checked around the latency edge
    task automatic rd(input int lat, input logic sp, input logic [17:0] e);
        i_lld_ctrl_model.issue(CMD_READ, 22'h5, 3'h2);
        if (sp)
            i_lld_ctrl_model.issue(CMD_IDLE, 22'h5, 3'h2);
        idle(lat - 1 - sp);
        check("lead", 2'h2, vf);
        idle(1);
        check("burst", {1'b1, e, 2'h1, 2'h1}, {oe, dq, vf, tdq, tmask});
        idle(1);
        check("end", {1'b0, 18'h0, 2'h0, 1'b1}, {oe, dq, vf, tdq});
        idle(2);
    endtask
    task automatic wr(input logic [17:0] d, input logic [1:0] m);
        i_lld_ctrl_model.issue(CMD_WRITE, 22'h5, 3'h2);
        i_lld_ctrl_model.put(d, m, 1'b1);
        idle(30);
        i_lld_ctrl_model.put(~d, ~m, 1'b0);
    endtask
    task automatic t_strobe();
        logic s;
        for (int i = 0; i < 4; i++)
        begin
            s = mstrb;
            idle(1);
            check("strobe", {~s}, mstrb);
        end
        $display("test strobe done");
    endtask
    task automatic t_wr_rd();
        logic [17:0] a = 18'h2A5C3;
        logic [17:0] b = 18'h1B4D2;
        ms(22'h100200, 18'h00200);
        wr(a, 2'h0);
        wr(b, 2'h2);
        stored = {a[17:9], b[8:0]};
        rd(4, 1'b0, stored);
        $display("test write read done");
    endtask
    task automatic t_pair_ref();
        i_lld_ctrl_model.issue(CMD_READ, 22'h5, 3'h2);
        i_lld_ctrl_model.issue(CMD_READ, 22'h5, 3'h2);
        idle(3);
        check("pair1", {1'b1, stored}, {oe, dq});
        idle(1);
        check("pair2", {1'b1, stored}, {oe, dq});
        idle(3);
        i_lld_ctrl_model.issue(CMD_REF, ~addr, 3'h1);
        i_lld_ctrl_model.issue(CMD_REF, ~addr, 3'h2);
        for (int i = 0; i < 3; i++)
        begin
            check("refresh", {i < 2}, refd);
            idle(1);
        end
        idle(8);
        $display("test pair refresh done");
    endtask
    task automatic t_cfg();
        logic [2:0] cf[4] = '{3'h0, 3'h2, 3'h4, 3'h5};
        int lt[4] = '{4, 6, 3, 5};
        for (int i = 0; i < 4; i++)
        begin
            ms(22'h200 | cf[i], 18'h200 | cf[i]);
            rd(lt[i], 1'b0, stored);
        end
        ms(22'h206, 18'h205);
        i_lld_ctrl_model.issue(CMD_READ, 22'h5, 3'h2);
        clk_bad = 1'b1;
        idle(8);
        clk_bad = 1'b0;
        idle(4);
        check("hold", 1, {|vf});
        i_lld_ctrl_model.issue(CMD_READ, 22'h5, 3'h2);
        idle(8);
        check("drop", 0, {|vf});
        ms(22'h220, 18'h220);
        rd(5, 1'b1, stored);
        $display("test config done");
    endtask
    // Longer bursts in config 5: beat count and flag shape per length
    task automatic t_burst(input logic [17:0] m, input int n);
        ms({4'h0, m}, m);
        i_lld_ctrl_model.issue(CMD_READ, 22'h5, 3'h2);
        idle(4);
        for (int i = 0; i <= n; i++)
        begin
            idle(1);
            check("burst_len", {i < n, i < n - 1, i < n}, {oe, vf});
        end
        $display("test burst %0d done", n);
    endtask
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        clk_bad = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        i_lld_ctrl_model.put(18'h0, 2'h0, 1'b0);
        check("reset", 0, {mode, oe, vf, refd});
        t_strobe();
        t_wr_rd();
        t_pair_ref();
        t_cfg();
        t_burst(18'h20D, 2);
        t_burst(18'h215, 4);
        finish_test();
    end
endmodule
`default_nettype wire
